// ==== hw/ttcap_pkg.sv ====
package ttcap_pkg;
    // frame, event and expression geometry
    localparam int unsigned EVENTS      = 8;
    localparam int unsigned NSTATE      = 6;
    localparam int unsigned NIN         = 15;
    localparam int unsigned DATA_W      = 48;
    localparam int unsigned NEXPR       = 8;
    localparam int unsigned LOOP_W      = 16;
    localparam int unsigned FILT_W      = 4;
    localparam int unsigned PRESC_W     = 17;
    // register byte offsets
    localparam logic [11:0] ADDR_CTRL    = 12'h000;
    localparam logic [11:0] ADDR_DELAY   = 12'h004;
    localparam logic [11:0] ADDR_LOOP    = 12'h008;
    localparam logic [11:0] ADDR_FILTER  = 12'h00C;
    localparam logic [11:0] ADDR_PRESC   = 12'h010;
    localparam logic [11:0] ADDR_STATUS  = 12'h014;
    localparam logic [11:0] ADDR_CYCLES  = 12'h018;
    localparam logic [11:0] ADDR_LOOPCNT = 12'h01C;
    localparam logic [11:0] ADDR_TSTAMP  = 12'h020;
    localparam logic [5:0]  EXPR_PAGE    = 6'h02;   // 0x080..0x0BF, two terms per expression
    localparam logic [4:0]  EVENT_PAGE   = 5'h02;   // 0x100..0x17F, four words per event
    // control register fields
    localparam int unsigned CTRL_TRIG_EN = 0;
    localparam int unsigned CTRL_THEN    = 1;
    localparam int unsigned CTRL_OVF     = 2;
    localparam int unsigned CTRL_BRK_LSB = 4;
    localparam int unsigned CTRL_REC_LSB = 6;
    localparam int unsigned CTRL_EV_LSB  = 8;
    localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
    // status register fields
    localparam int unsigned STAT_ST_LSB  = 2;
    localparam int unsigned STAT_LD_BIT  = 8;
    // expression term word: care mask, match value, enable
    localparam int unsigned TERM_VAL_LSB = 16;
    localparam int unsigned TERM_EN_BIT  = 31;
    // expression slots and input vector positions
    localparam int unsigned X_TRIG       = 0;
    localparam int unsigned X_REC        = 1;
    localparam int unsigned X_S0         = 2;
    localparam int unsigned IN_ST_LSB    = 8;
    localparam int unsigned IN_LOOP_DONE = 14;
    // limits and reset values
    localparam logic [31:0] DELAY_MIN    = 32'h0000_0002;
    localparam logic [31:0] DELAY_MAX    = 32'h7FFF_FFFF;
    localparam logic [16:0] PRESC_MAX    = 17'h1FFFE;
    localparam logic [15:0] LOOP_RESET   = 16'h0000;
    localparam logic [15:0] TS_STEP_FULL = 16'h0002;

    typedef enum logic [1:0] {
        TTCAP_BRK_NONE = 2'b00,
        TTCAP_BRK_TRIG = 2'b01,
        TTCAP_BRK_DONE = 2'b10,
        TTCAP_BRK_S2   = 2'b11
    } ttcap_brk_e;

    typedef enum logic [1:0] {
        TTCAP_REC_ALWAYS = 2'b00,
        TTCAP_REC_COND   = 2'b01,
        TTCAP_REC_SOURCE = 2'b10
    } ttcap_rec_e;

    // gray along idle -> pre -> post -> done
    typedef enum logic [1:0] {
        TTCAP_IDLE = 2'b00,
        TTCAP_PRE  = 2'b01,
        TTCAP_POST = 2'b11,
        TTCAP_DONE = 2'b10
    } ttcap_cap_e;
endpackage

// ==== hw/ttcap_trace_trigger_capture.sv ====
`timescale 1ns/1ps
// Summary of operation
// - capture starts at every emulation start
// - after trigger, count delay frames then stop
// - delay defaults to half buffer depth
// - loop counter 0..65535 sets loop-done at zero
// - loop counter decrements on condition rising edge
// - break on trigger, or never in none
// - break when post-trigger capture stops
// - break when state bit two rises
// - store all frames, or record-expression frames
// - source mode stores only source-line frames
// - record expression is purely combinational
// - filter delay keeps 0..15 frames after record
// - prescaler plus 16-bit stored timestamp
// - no prescale counts half cycles, wraps
// - prescale even only, capped, odd rounded down
// - overflow forces a store at timestamp wrap
// - 32-bit cycle counter counts while bit five
// - bit five drives the pod count pin
// - pod condition output low while bit four
// - THEN trigger consumes state bits zero to two
// - six registered programmable state bits
// - eight masked events compared each frame
// - THEN true only when second follows first
// - state terms take effect one frame later
module ttcap_trace_trigger_capture #(
    parameter int unsigned DEPTH_FRAMES = 65536
) (
    input  wire logic        clk_sys_i,
    input  wire logic        resetn_i,
    input  wire logic        ce_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic        emul_run_i,
    input  wire logic        frame_valid_i,
    input  wire logic [47:0] frame_data_i,
    input  wire logic        frame_source_i,
    output logic             capture_active_o,
    output logic             frame_store_o,
    output logic      [15:0] frame_ts_o,
    output logic             trigger_o,
    output logic             break_req_o,
    output logic             pod_condition_output_o,
    output logic             pod_count_enable_pin_o
);
    localparam logic [31:0] DELAY_DEFAULT = 32'(DEPTH_FRAMES / 2);

    // depth must leave a legal half-depth delay
    if (DEPTH_FRAMES < 4 || DEPTH_FRAMES > 32'h8000_0000) begin : g_depth_check
        $error("DEPTH_FRAMES out of range");
    end

    // one term: enabled and all cared-for inputs match
    function automatic logic term_hit(input logic [14:0] in, input logic [31:0] t);
        term_hit = t[ttcap_pkg::TERM_EN_BIT]
                   & ~|((in ^ t[ttcap_pkg::TERM_VAL_LSB +: 15]) & t[14:0]);
    endfunction

    // sum of two product terms
    function automatic logic expr_eval(input logic [14:0] in, input logic [31:0] t0,
                                       input logic [31:0] t1);
        expr_eval = term_hit(in, t0) | term_hit(in, t1);
    endfunction

    function automatic logic [31:0] clamp_delay(input logic [31:0] v);
        clamp_delay = v[31] ? ttcap_pkg::DELAY_MAX
                    : (v < ttcap_pkg::DELAY_MIN ? ttcap_pkg::DELAY_MIN : v);
    endfunction

    logic [31:0]             ctrl;
    logic [31:0]             delay_cfg;
    logic [15:0]             loop_cfg;
    logic [3:0]              filter_cfg;
    logic [16:0]             presc_cfg;
    logic [31:0]             expr_term [2*ttcap_pkg::NEXPR];
    logic [47:0]             ev_val    [ttcap_pkg::EVENTS];
    logic [47:0]             ev_care   [ttcap_pkg::EVENTS];
    ttcap_pkg::ttcap_cap_e   cap_st;
    ttcap_pkg::ttcap_cap_e   next_cap_st;
    logic [5:0]              states;
    logic [5:0]              next_states;
    logic [15:0]             loop_cnt;
    logic [31:0]             post_cnt;
    logic [3:0]              filter_cnt;
    logic [15:0]             ps_cnt;
    logic [15:0]             ts;
    logic [31:0]             cycles;
    logic                    run_q;
    logic                    ack_q;
    logic [31:0]             rd_mux;

    // bus decode
    wire        acc_first  = ce_i & psel_i & penable_i & ~ack_q;
    wire        wr_commit  = ce_i & psel_i & penable_i & ack_q & pwrite_i;
    wire        in_expr    = paddr_i[11:6] == ttcap_pkg::EXPR_PAGE;
    wire        in_event   = paddr_i[11:7] == ttcap_pkg::EVENT_PAGE;
    wire [11:0] reg_addr   = {paddr_i[11:2], 2'b00};
    wire [3:0]  expr_idx   = paddr_i[5:2];
    wire [2:0]  ev_idx     = paddr_i[6:4];
    wire [1:0]  ev_word    = paddr_i[3:2];
    wire        addr_ok    = in_expr | in_event | (reg_addr <= ttcap_pkg::ADDR_TSTAMP);
    wire        ro_addr    = reg_addr >= ttcap_pkg::ADDR_STATUS;

    // one wait state so read data leaves a flop
    assign pready_o  = ack_q;
    assign pslverr_o = ack_q & ~addr_ok;

    // control fields
    wire ttcap_pkg::ttcap_brk_e brk_mode =
        ttcap_pkg::ttcap_brk_e'(ctrl[ttcap_pkg::CTRL_BRK_LSB +: 2]);
    wire ttcap_pkg::ttcap_rec_e rec_mode =
        ttcap_pkg::ttcap_rec_e'(ctrl[ttcap_pkg::CTRL_REC_LSB +: 2]);
    wire        then_mode  = ctrl[ttcap_pkg::CTRL_THEN];
    wire        trig_en    = ctrl[ttcap_pkg::CTRL_TRIG_EN];
    wire        ovf_en     = ctrl[ttcap_pkg::CTRL_OVF];
    wire [15:0] ps_half    = presc_cfg[16:1];

    // masked compare of each frame against eight events
    wire [7:0] ev_hit;
    for (genvar e = 0; e < ttcap_pkg::EVENTS; e++) begin : g_event
        assign ev_hit[e] = ctrl[ttcap_pkg::CTRL_EV_LSB + e]
                           & ~|((frame_data_i ^ ev_val[e]) & ev_care[e]);
    end

    wire        loop_done = loop_cnt == 16'h0000;
    wire [14:0] ex_in     = {loop_done, states, ev_hit};
    wire [7:0]  x_val;
    // every expression is a combinational sum of products
    for (genvar x = 0; x < ttcap_pkg::NEXPR; x++) begin : g_expr
        assign x_val[x] = expr_eval(ex_in, expr_term[2*x], expr_term[2*x+1]);
    end

    // THEN mode uses bit zero as the sequence latch
    wire then_first = term_hit(ex_in, expr_term[2*ttcap_pkg::X_TRIG]);
    wire then_last  = term_hit(ex_in, expr_term[2*ttcap_pkg::X_TRIG+1]);
    // next value of each state bit is its own expression, except bits zero to two in THEN mode
    assign next_states[0]   = then_mode ? (states[0] | then_first) : x_val[ttcap_pkg::X_S0];
    assign next_states[2:1] = then_mode ? 2'b00 : x_val[ttcap_pkg::X_S0+1 +: 2];
    assign next_states[5:3] = x_val[ttcap_pkg::X_S0+3 +: 3];
    // second operand only counts after bit zero has latched
    wire trig_cond = then_mode ? (states[0] & then_last) : x_val[ttcap_pkg::X_TRIG];

    wire run_start = emul_run_i & ~run_q;
    wire frame     = frame_valid_i;
    wire capturing = (cap_st == ttcap_pkg::TTCAP_PRE) | (cap_st == ttcap_pkg::TTCAP_POST);
    // only the armed pre-trigger phase may fire
    wire trig_fire = frame & (cap_st == ttcap_pkg::TTCAP_PRE) & trig_en & trig_cond;
    wire post_done = frame & (cap_st == ttcap_pkg::TTCAP_POST) & (post_cnt == 32'h1);
    wire loop_rise = next_states[3] & ~states[3];
    wire s2_rise   = next_states[2] & ~states[2];

    // source mode follows the frame's line flag
    wire rec_qual = (rec_mode == ttcap_pkg::TTCAP_REC_COND)
                    ? (x_val[ttcap_pkg::X_REC] | (filter_cnt != 4'h0))
                    : (rec_mode == ttcap_pkg::TTCAP_REC_SOURCE) ? frame_source_i : 1'b1;

    // prescaler divides, only the 16-bit count is stored
    // without prescale the count moves two half cycles per frame
    wire        ps_none = ps_half == 16'h0000;
    wire        ts_tick = ps_none | (ps_cnt >= ps_half - 16'h1);
    wire [15:0] next_ts = ts + (ps_none ? ttcap_pkg::TS_STEP_FULL : 16'h0001);
    wire        ts_wrap = frame & ts_tick & (next_ts < ts);
    // at wrap a frame the record logic would drop is kept
    wire        forced  = ovf_en & ts_wrap & ~rec_qual;
    wire        store   = frame & capturing & (rec_qual | forced);

    // trigger break, done break, state-two break
    wire brk_next = ((brk_mode == ttcap_pkg::TTCAP_BRK_TRIG) & trig_fire)
                  | ((brk_mode == ttcap_pkg::TTCAP_BRK_DONE) & post_done)
                  | ((brk_mode == ttcap_pkg::TTCAP_BRK_S2) & frame & s2_rise);

    // capture sequencer
    always_comb begin
        next_cap_st = cap_st;
        case (cap_st)
            ttcap_pkg::TTCAP_IDLE: next_cap_st = cap_st;
            ttcap_pkg::TTCAP_PRE:  if (trig_fire) next_cap_st = ttcap_pkg::TTCAP_POST;
            ttcap_pkg::TTCAP_POST: if (post_done) next_cap_st = ttcap_pkg::TTCAP_DONE;
            ttcap_pkg::TTCAP_DONE: next_cap_st = cap_st;
            default:               next_cap_st = ttcap_pkg::TTCAP_IDLE;
        endcase
        // a new run always re-arms capture
        if (run_start) next_cap_st = ttcap_pkg::TTCAP_PRE;
    end

    // register read mux
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (in_expr) begin
            rd_mux = expr_term[expr_idx];
        end else if (in_event) begin
            case (ev_word)
                2'b00:   rd_mux = ev_val[ev_idx][31:0];
                2'b01:   rd_mux = {16'h0000, ev_val[ev_idx][47:32]};
                2'b10:   rd_mux = ev_care[ev_idx][31:0];
                default: rd_mux = {16'h0000, ev_care[ev_idx][47:32]};
            endcase
        end else begin
            case (reg_addr)
                ttcap_pkg::ADDR_CTRL:    rd_mux = ctrl;
                ttcap_pkg::ADDR_DELAY:   rd_mux = delay_cfg;
                ttcap_pkg::ADDR_LOOP:    rd_mux = {16'h0000, loop_cfg};
                ttcap_pkg::ADDR_FILTER:  rd_mux = {28'h0000000, filter_cfg};
                ttcap_pkg::ADDR_PRESC:   rd_mux = {15'h0000, presc_cfg};
                ttcap_pkg::ADDR_STATUS:  rd_mux = {23'h000000, loop_done, states, cap_st};
                ttcap_pkg::ADDR_CYCLES:  rd_mux = cycles;
                ttcap_pkg::ADDR_LOOPCNT: rd_mux = {16'h0000, loop_cnt};
                ttcap_pkg::ADDR_TSTAMP:  rd_mux = {16'h0000, ts};
                default:                 rd_mux = 32'h0000_0000;
            endcase
        end
    end

    // bus handshake and read data
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            ack_q    <= 1'b0;
            prdata_o <= 32'h0000_0000;
        end else if (ce_i) begin
            ack_q <= acc_first;
            if (acc_first) prdata_o <= rd_mux;
        end
    end

    // scalar configuration writes, delay and prescale values clamped on the way in
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            ctrl       <= ttcap_pkg::CTRL_RESET;
            delay_cfg  <= DELAY_DEFAULT;        // half depth by default
            loop_cfg   <= ttcap_pkg::LOOP_RESET;
            filter_cfg <= 4'h0;
            presc_cfg  <= 17'h00000;
        end else if (wr_commit & ~in_expr & ~in_event & ~ro_addr) begin
            case (reg_addr)
                ttcap_pkg::ADDR_CTRL:   ctrl <= pwdata_i;
                ttcap_pkg::ADDR_DELAY:  delay_cfg <= clamp_delay(pwdata_i);
                ttcap_pkg::ADDR_LOOP:   loop_cfg <= pwdata_i[15:0];
                ttcap_pkg::ADDR_FILTER: filter_cfg <= pwdata_i[3:0];
                // even only, odd rounds down, capped
                ttcap_pkg::ADDR_PRESC:  presc_cfg <= (pwdata_i > 32'(ttcap_pkg::PRESC_MAX))
                                                   ? ttcap_pkg::PRESC_MAX
                                                   : {pwdata_i[16:1], 1'b0};
                default:                ctrl <= ctrl;
            endcase
        end
    end

    // expression terms and event patterns; no reset, software loads before a run
    always_ff @(posedge clk_sys_i) begin
        if (wr_commit & in_expr) expr_term[expr_idx] <= pwdata_i;
        if (wr_commit & in_event) begin
            case (ev_word)
                2'b00:   ev_val[ev_idx][31:0]   <= pwdata_i;
                2'b01:   ev_val[ev_idx][47:32]  <= pwdata_i[15:0];
                2'b10:   ev_care[ev_idx][31:0]  <= pwdata_i;
                default: ev_care[ev_idx][47:32] <= pwdata_i[15:0];
            endcase
        end
    end

    // capture state and post-trigger delay
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            cap_st   <= ttcap_pkg::TTCAP_IDLE;
            post_cnt <= 32'h0000_0000;
            run_q    <= 1'b0;
        end else if (ce_i) begin
            run_q  <= emul_run_i;
            cap_st <= next_cap_st;
            // load at trigger, count frames down to the stop
            if (trig_fire) post_cnt <= delay_cfg;
            else if (frame & (cap_st == ttcap_pkg::TTCAP_POST)) post_cnt <= post_cnt - 32'h1;
        end
    end

    // state bits, loop counter and cycle counter
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            states   <= 6'h00;
            loop_cnt <= ttcap_pkg::LOOP_RESET;
            cycles   <= 32'h0000_0000;
        end else if (ce_i) begin
            if (run_start) begin
                states   <= 6'h00;
                loop_cnt <= loop_cfg;           // loaded at each run start
                cycles   <= 32'h0000_0000;
            end else if (frame) begin
                // registered, so a set shows one frame later
                states <= next_states;
                if (loop_rise & ~loop_done) loop_cnt <= loop_cnt - 16'h1;
                // count while bit five's expression holds
                if (next_states[5]) cycles <= cycles + 32'h1;
            end
        end
    end

    // timestamp, filter delay and registered outputs
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            ts            <= 16'h0000;
            ps_cnt        <= 16'h0000;
            filter_cnt    <= 4'h0;
            frame_store_o <= 1'b0;
            frame_ts_o    <= 16'h0000;
            trigger_o     <= 1'b0;
            break_req_o   <= 1'b0;
        end else if (ce_i) begin
            frame_store_o <= store;
            trigger_o     <= trig_fire;
            break_req_o   <= brk_next;
            if (store) frame_ts_o <= next_ts;
            if (run_start) begin
                ts         <= 16'h0000;
                ps_cnt     <= 16'h0000;
                filter_cnt <= 4'h0;
            end else if (frame) begin
                ts     <= ts_tick ? next_ts : ts;
                ps_cnt <= ts_tick ? 16'h0000 : ps_cnt + 16'h1;
                // reload while true, drain after it falls
                if (x_val[ttcap_pkg::X_REC]) filter_cnt <= filter_cfg;
                else if (filter_cnt != 4'h0) filter_cnt <= filter_cnt - 4'h1;
            end
        end
    end

    assign capture_active_o       = capturing;
    // active-low pod condition follows bit four
    assign pod_condition_output_o = ~states[4];
    // bit five straight to the pod pin
    assign pod_count_enable_pin_o = states[5];

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);

    a_break_none: assert property (
        break_req_o |-> $past(brk_mode) != ttcap_pkg::TTCAP_BRK_NONE)
        else $error("break requested in none mode");
    a_break_trig: assert property (
        (ce_i && trig_fire && brk_mode == ttcap_pkg::TTCAP_BRK_TRIG) |=> break_req_o && trigger_o)
        else $error("trigger break not coincident with trigger");
    a_trig_latch: assert property (
        (ce_i && trig_fire && !run_start) |=> cap_st == ttcap_pkg::TTCAP_POST
                                              && post_cnt == $past(delay_cfg) && !trig_fire)
        else $error("trigger did not latch with delay loaded");
    a_post_stop: assert property (
        (ce_i && post_done && !run_start) |=> cap_st == ttcap_pkg::TTCAP_DONE
            && (break_req_o == ($past(brk_mode) == ttcap_pkg::TTCAP_BRK_DONE
                || ($past(brk_mode) == ttcap_pkg::TTCAP_BRK_S2 && $past(s2_rise)))))
        else $error("capture did not stop at end of delay");
    a_store_all: assert property (
        (ce_i && frame && capturing && rec_mode == ttcap_pkg::TTCAP_REC_ALWAYS) |=> frame_store_o)
        else $error("always mode dropped a frame");
    a_store_idle: assert property (
        frame_store_o |-> $past(capturing) && $past(frame_valid_i))
        else $error("frame stored outside capture");
    a_loop_step: assert property (
        (ce_i && frame && !run_start && loop_cnt != 16'h0000)
        |=> loop_cnt == $past(loop_cnt) - 16'($past(loop_rise)))
        else $error("loop counter stepped wrongly");
    a_pod_level: assert property (
        (ce_i && frame && !run_start) |=> pod_condition_output_o == !$past(x_val[6]))
        else $error("pod condition does not follow its expression");
    a_cycle_cnt: assert property (
        (ce_i && frame && !run_start) |=> cycles == $past(cycles) + 32'($past(next_states[5])))
        else $error("cycle counter miscounted");
    a_cfg_ranges: assert property (
        !presc_cfg[0] && presc_cfg <= ttcap_pkg::PRESC_MAX && delay_cfg >= ttcap_pkg::DELAY_MIN
        && delay_cfg <= ttcap_pkg::DELAY_MAX)
        else $error("configuration outside legal range");

    c_trigger: cover property (ce_i && trig_fire);
    c_done:    cover property (ce_i && post_done);
    c_forced:  cover property (ce_i && forced && capturing);
    c_loop:    cover property (ce_i && loop_rise && loop_cnt == 16'h0001);
endmodule

// ==== tb/ttcap_target_bus.sv ====
`timescale 1ns/1ps
// far side: a burst of back-to-back bus frames whose data is the frame index
module ttcap_target_bus (
    input  wire logic        clk_sys_i,
    input  wire logic        resetn_i,
    input  wire logic        start_i,
    input  wire logic [7:0]  nframes_i,
    output logic             frame_valid_o,
    output logic      [47:0] frame_data_o,
    output logic             frame_source_o
);
    logic [7:0] left;
    logic [7:0] idx;
    // burst length and index counters
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i || start_i) begin
            left <= resetn_i ? nframes_i : 8'h00;
            idx  <= 8'h00;
        end else if (left != 8'h00) begin
            left <= left - 8'h01;
            idx  <= idx + 8'h01;
        end
    end
    // outside a frame the lines show the inverse, so stale data never looks valid
    assign frame_valid_o  = (left != 8'h00);
    assign frame_data_o   = frame_valid_o ? {40'h0, idx} : ~{40'h0, idx};
    assign frame_source_o = frame_valid_o ? idx[0] : ~idx[0];
endmodule

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
module testbench;
    logic        clk_sys_i, resetn_i, psel, penable, pwrite, emul_run, start;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic        pready, pslverr, fv, fsrc, store, trig, brk, podn, podpin;
    logic [7:0]  nfr;
    logic [15:0] fts;
    logic [47:0] fdata;
    int          err_count, total_checks, n_st, n_tr, n_bk, n_pd, n_pp, m;

    ttcap_trace_trigger_capture dut_u (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
        .ce_i(1'b1), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .emul_run_i(emul_run), .frame_valid_i(fv),
        .frame_data_i(fdata), .frame_source_i(fsrc), .capture_active_o(),
        .frame_store_o(store), .frame_ts_o(fts), .trigger_o(trig), .break_req_o(brk),
        .pod_condition_output_o(podn), .pod_count_enable_pin_o(podpin));
    ttcap_target_bus bus_u (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .start_i(start),
        .nframes_i(nfr), .frame_valid_o(fv), .frame_data_o(fdata), .frame_source_o(fsrc));

    initial begin
        clk_sys_i = 1'b0;
        forever #2 clk_sys_i = ~clk_sys_i;
    end
    // pulse and level counters on the design's frame-side outputs
    always @(posedge clk_sys_i) begin
        n_st += int'(store === 1'b1);
        n_tr += int'(trig === 1'b1);
        n_bk += int'(brk === 1'b1);
        n_pd += int'(podn === 1'b0);
        n_pp += int'(podpin === 1'b1);
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one apb transfer, held until pready is seen high at a rising edge
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
                       input logic [31:0] e, input logic ee);
        psel <= 1'b1; penable <= 1'b0; paddr <= a; pwrite <= w; pwdata <= d;
        @(posedge clk_sys_i);
        penable <= 1'b1;
        do @(posedge clk_sys_i); while (pready !== 1'b1);
        if (!w) chk(prdata, e);
        chk({31'h0, pslverr}, {31'h0, ee});
        psel <= 1'b0; penable <= 1'b0;
        @(posedge clk_sys_i);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(a, 1'b1, d, 32'h0, 1'b0);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(a, 1'b0, 32'h0, e, 1'b0);
    endtask
    // restart emulation, send n frames, compare output counts
    task automatic run(input logic [7:0] n, input int est, etr, ebk, epd);
        int s, t, b, p, q;
        s = n_st; t = n_tr; b = n_bk; p = n_pd; q = n_pp;
        emul_run <= 1'b0;
        @(posedge clk_sys_i);
        emul_run <= 1'b1; start <= 1'b1; nfr <= n;
        @(posedge clk_sys_i);
        start <= 1'b0;
        do @(posedge clk_sys_i); while (fv === 1'b1);
        repeat (4) @(posedge clk_sys_i);
        chk(32'(n_st - s), 32'(est));
        chk(32'(n_tr - t), 32'(etr));
        chk(32'(n_bk - b), 32'(ebk));
        chk(32'(n_pd - p), 32'(epd));
        chk(32'(n_pp - q), 32'(epd));
        $display("test run of %0d frames done", n);
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    initial begin
        {resetn_i, psel, penable, pwrite, emul_run, start} = 6'h0;
        {paddr, pwdata, nfr} = 52'h0;
        {err_count, total_checks, n_st, n_tr, n_bk, n_pd, n_pp} = 224'h0;
        repeat (3) @(posedge clk_sys_i);
        resetn_i <= 1'b1;
        @(posedge clk_sys_i);
        rd(ttcap_pkg::ADDR_CTRL, ttcap_pkg::CTRL_RESET);
        rd(ttcap_pkg::ADDR_DELAY, 32'h8000);
        rd(ttcap_pkg::ADDR_LOOP, 32'h0);
        wr(ttcap_pkg::ADDR_STATUS, 32'hFFFFFFFF);
        rd(ttcap_pkg::ADDR_STATUS, 32'h100);
        apb(12'h040, 1'b0, 32'h0, 32'h0, 1'b1);
        wr(ttcap_pkg::ADDR_DELAY, 32'h0);
        rd(ttcap_pkg::ADDR_DELAY, ttcap_pkg::DELAY_MIN);
        wr(ttcap_pkg::ADDR_DELAY, 32'hFFFFFFFF);
        rd(ttcap_pkg::ADDR_DELAY, ttcap_pkg::DELAY_MAX);
        wr(ttcap_pkg::ADDR_PRESC, 32'h3);
        rd(ttcap_pkg::ADDR_PRESC, 32'h2);
        wr(ttcap_pkg::ADDR_PRESC, 32'h1FFFF);
        rd(ttcap_pkg::ADDR_PRESC, {15'h0, ttcap_pkg::PRESC_MAX});
        $display("test registers done");
        // event A matches every frame index ending in binary 11
        for (m = 0; m < 16; m++) wr(12'h080 + 12'(4 * m), 32'h0);
        wr(12'h100, 32'h3);
        wr(12'h104, 32'h0);
        wr(12'h108, 32'h3);
        wr(12'h10C, 32'h0);
        wr(12'h080, 32'h80010001);
        wr(ttcap_pkg::ADDR_DELAY, 32'h4);
        wr(ttcap_pkg::ADDR_PRESC, 32'h0);
        // state bit two sets on event A and then holds itself
        wr(12'h0A0, 32'h80010001);
        wr(12'h0A4, 32'h84000400);
        for (m = 0; m < 4; m++) begin
            wr(ttcap_pkg::ADDR_CTRL, 32'h101 | 32'(m << 4));
            run(8'h14, 8, 1, int'(m != 0), 0);
        end
        wr(12'h088, 32'h80010001);
        wr(ttcap_pkg::ADDR_CTRL, 32'h140);
        run(8'h14, 5, 0, 0, 0);
        wr(ttcap_pkg::ADDR_FILTER, 32'h2);
        run(8'h14, 13, 0, 0, 0);
        wr(ttcap_pkg::ADDR_CTRL, 32'h180);
        run(8'h14, 10, 0, 0, 0);
        wr(12'h0A8, 32'h80010001);
        wr(12'h0B0, 32'h80010001);
        wr(12'h0B8, 32'h80010001);
        // last frame misses A, so pod levels settle idle once the burst ends
        wr(ttcap_pkg::ADDR_LOOP, 32'h4);
        wr(ttcap_pkg::ADDR_CTRL, 32'h100);
        run(8'h13, 19, 0, 0, 4);
        rd(ttcap_pkg::ADDR_CYCLES, 32'h4);
        rd(ttcap_pkg::ADDR_LOOPCNT, 32'h0);
        rd(ttcap_pkg::ADDR_TSTAMP, 32'h26);
        wr(ttcap_pkg::ADDR_PRESC, 32'h4);
        run(8'h13, 19, 0, 0, 4);
        rd(ttcap_pkg::ADDR_TSTAMP, 32'h9);
        // A then A: only the second A fires, four delay frames follow
        wr(12'h084, 32'h80010001);
        wr(ttcap_pkg::ADDR_CTRL, 32'h103);
        run(8'h13, 12, 1, 0, 4);
        rd(ttcap_pkg::ADDR_STATUS, 32'h106);
        chk({16'h0, fts}, 32'h6);
        summarize();
    end
    initial begin
        repeat (20000) @(posedge clk_sys_i);
        err_count++;
        summarize();
    end
endmodule
